//--- hdl/cvbf_defines.vh
// constants of the cyclic value block framer
`ifndef CVBF_DEFINES_VH
`define CVBF_DEFINES_VH
// register byte offsets
`define CVBF_OFF_CTRL 5'h00
`define CVBF_OFF_SELECTOR 5'h04
`define CVBF_OFF_SLOTCFG 5'h08
`define CVBF_OFF_UNITS 5'h0C
`define CVBF_OFF_STATUS 5'h10
`define CVBF_OFF_DISPVAL 5'h14
`define CVBF_OFF_DISPSTAT 5'h18
// control fields
`define CVBF_CTRL_COMPACT 0
`define CVBF_CTRL_DISPSRC 1
`define CVBF_CTRL_RST 32'h00000000
// slot configuration: enables in [3:0], channel of slot i at [8+3*i +: 3]
`define CVBF_SLOTCFG_RST 32'h0000000F
`define CVBF_UNITS_RST 32'h00000000
`define CVBF_SELECTOR_RST 8'h01
// status fields
`define CVBF_STAT_COMM 0
`define CVBF_STAT_NEWPROF 1
`define CVBF_STAT_DISPVALID 2
`define CVBF_STAT_RXERR 3
// selector codes
`define CVBF_SEL_PROFILE4 8'h00
`define CVBF_SEL_MAKER 8'h01
`define CVBF_SEL_AUTO 8'h7F
`define CVBF_SEL_PROFILE1 8'h81
`define CVBF_SEL_PROFILE2 8'h82
`define CVBF_SEL_PROFILE3 8'h83
// block layout
`define CVBF_BLOCK_BYTES 5
`define CVBF_AI_SLOTS 4
`define CVBF_CHANNELS 5
// quality classes of a source
`define CVBF_Q_BAD 2'h0
`define CVBF_Q_UNCERTAIN 2'h1
`define CVBF_Q_GOOD 2'h2
// status codes, older and newer variant
`define CVBF_OLD_GOOD 8'h80
`define CVBF_OLD_UNC 8'h40
`define CVBF_OLD_BAD 8'h00
`define CVBF_NEW_GOOD 8'h80
`define CVBF_NEW_UNC 8'h68
`define CVBF_NEW_BAD 8'h24
// timing
`define CVBF_CLK_HZ 20000000
`define CVBF_COMM_TIMEOUT_MS 1000
`define CVBF_FLASH_MS 500
`define CVBF_COMM_TIMEOUT_CYC (`CVBF_COMM_TIMEOUT_MS * (`CVBF_CLK_HZ / 1000))
`define CVBF_FLASH_CYC (`CVBF_FLASH_MS * (`CVBF_CLK_HZ / 1000))
`endif

//--- hdl/cvbf_fifo.v
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module cvbf_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_sys,
  input wire nrst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire doWrite;
  wire doRead;

  // honest full and empty from the fill count
  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_reg];
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;

  // storage, no reset needed on data
  always @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // pointers wrap at the last entry
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // cvbf_fifo

//--- hdl/cvbf_framer.v
// cyclic value block framer: analog-input blocks out, display block in
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "cvbf_defines.vh"
module cvbf_framer #(
  parameter COMM_TIMEOUT_CYC = `CVBF_COMM_TIMEOUT_CYC,
  parameter FLASH_CYC = `CVBF_FLASH_CYC,
  parameter FIFO_DEPTH = 4
) (
  input wire clk_sys,
  input wire nrst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire cycStart,
  input wire estProfileNew,
  input wire [159:0] srcValues,
  input wire [9:0] srcQual,
  output wire [7:0] txData,
  output wire txLast,
  output wire txValid,
  input wire txReady,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire rxLast,
  output wire [9:0] chanUnit,
  output wire [31:0] dispValue,
  output wire [7:0] dispStatus,
  output wire dispArrow,
  output wire commActive
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SCAN = 2'h1;
  localparam ST_PUSH = 2'h2;

  reg [31:0] ctrl_reg, slotCfg_reg, units_reg, readData_reg, rxValue_reg, dispValue_reg, readMux;
  reg [7:0] selector_reg, rxStatus_reg, dispStatus_reg;
  reg rxErr_reg, ack_reg, dispValid_reg, arrowPhase_reg, pushValid, anyLater;
  reg [1:0] state_reg, state_next;
  reg [2:0] slotIdx_reg, slotIdx_next, byteIdx_reg, byteIdx_next, rxCnt_reg, slotLimit;
  reg [39:0] txWord_reg, txWord_next, rxShift_reg;
  reg lastSlot_reg, lastSlot_next;
  reg [24:0] commTimer_reg, flashTimer_reg;
  integer k;
  wire accessReq, wrStrobe, useNewProfile, rxBlockDone, rxShortErr, fifoInReady;
  wire [8:0] fifoOut;
  wire [2:0] curChan;

  // pick channel value, out-of-range selection gives zero
  function [31:0] chanValue;
    input [2:0] sel;
    input [159:0] vals;
    begin
      if (sel < 3'h5) begin
        chanValue = vals[32*sel +: 32];
      end else begin
        chanValue = 32'h00000000;
      end
    end
  endfunction

  // status code from quality class and variant
  function [7:0] statusCode;
    input [1:0] qual;
    input newProf;
    begin
      case (qual)
        `CVBF_Q_GOOD: statusCode = newProf ? `CVBF_NEW_GOOD : `CVBF_OLD_GOOD;
        `CVBF_Q_UNCERTAIN: statusCode = newProf ? `CVBF_NEW_UNC : `CVBF_OLD_UNC;
        default: statusCode = newProf ? `CVBF_NEW_BAD : `CVBF_OLD_BAD;
      endcase
    end
  endfunction

  // byte n of a block, byte 0 is the most significant
  function [7:0] blockByte;
    input [39:0] word;
    input [2:0] idx;
    begin
      blockByte = word[39 - 8*idx -: 8];
    end
  endfunction

  // byte-enabled update of a register word
  function [31:0] beMerge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0] be;
    integer b;
    begin
      beMerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          beMerge[8*b +: 8] = wdata[8*b +: 8];
        end
      end
    end
  endfunction

  // bus handshake: one wait cycle, then the answer
  assign accessReq = avs_read | avs_write;
  assign avs_waitrequest = accessReq & ~ack_reg;
  assign wrStrobe = avs_write & ack_reg;
  assign avs_readdata = readData_reg;

  assign useNewProfile = (selector_reg == `CVBF_SEL_AUTO) ? estProfileNew :
    (selector_reg == `CVBF_SEL_MAKER) & ctrl_reg[`CVBF_CTRL_COMPACT];

  // profile selectors cap the slot count
  always @* begin
    case (selector_reg)
      `CVBF_SEL_PROFILE1: slotLimit = 3'h1;
      `CVBF_SEL_PROFILE2: slotLimit = 3'h2;
      `CVBF_SEL_PROFILE3: slotLimit = 3'h3;
      default: slotLimit = 3'h4;
    endcase
  end

  // register read mux, unmapped reads as zero
  always @* begin
    case (avs_address)
      `CVBF_OFF_CTRL: readMux = ctrl_reg;
      `CVBF_OFF_SELECTOR: readMux = {24'h000000, selector_reg};
      `CVBF_OFF_SLOTCFG: readMux = slotCfg_reg;
      `CVBF_OFF_UNITS: readMux = units_reg;
      `CVBF_OFF_STATUS: readMux = {28'h0000000, rxErr_reg, dispValid_reg, useNewProfile, commActive};
      `CVBF_OFF_DISPVAL: readMux = rxValue_reg;
      `CVBF_OFF_DISPSTAT: readMux = {24'h000000, rxStatus_reg};
      default: readMux = 32'h00000000;
    endcase
  end

  // bus slave registers
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      readData_reg <= 32'h00000000;
      ctrl_reg <= `CVBF_CTRL_RST;
      selector_reg <= `CVBF_SELECTOR_RST;
      slotCfg_reg <= `CVBF_SLOTCFG_RST;
      units_reg <= `CVBF_UNITS_RST;
    end else begin
      ack_reg <= accessReq & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        readData_reg <= readMux;
      end
      if (wrStrobe) begin
        case (avs_address)
          `CVBF_OFF_CTRL: ctrl_reg <= beMerge(ctrl_reg, avs_writedata, avs_byteenable) & 32'h00000003;
          `CVBF_OFF_SELECTOR: selector_reg <= avs_byteenable[0] ? avs_writedata[7:0] : selector_reg;
          `CVBF_OFF_SLOTCFG: slotCfg_reg <= beMerge(slotCfg_reg, avs_writedata, avs_byteenable) & 32'h000FFF0F;
          // per-channel unit codes, zero is Celsius
          `CVBF_OFF_UNITS: units_reg <= beMerge(units_reg, avs_writedata, avs_byteenable) & 32'h000003FF;
          default: ;
        endcase
      end
    end
  end

  // unit codes go to the measuring front end
  assign chanUnit = units_reg[9:0];

  // channel of the slot being scanned
  // five channel choices, codes 0 to 4
  assign curChan = slotCfg_reg[8 + 3*slotIdx_reg +: 3];

  // is there an enabled slot after the current one
  always @* begin
    anyLater = 1'b0;
    for (k = 0; k < `CVBF_AI_SLOTS; k = k + 1) begin
      if ((k > slotIdx_reg) && (k < slotLimit) && slotCfg_reg[k]) begin
        anyLater = 1'b1;
      end
    end
  end

  // transmit sequencer for slots one to four
  always @* begin
    state_next = state_reg;
    slotIdx_next = slotIdx_reg;
    byteIdx_next = byteIdx_reg;
    txWord_next = txWord_reg;
    lastSlot_next = lastSlot_reg;
    pushValid = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (cycStart) begin
          slotIdx_next = 3'h0;
          state_next = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (slotIdx_reg >= slotLimit) begin
          state_next = ST_IDLE;
        end else if (slotCfg_reg[slotIdx_reg]) begin
          txWord_next = {chanValue(curChan, srcValues),
            (curChan < 3'h5) ? statusCode(srcQual[2*curChan +: 2], useNewProfile) : statusCode(`CVBF_Q_BAD, useNewProfile)};
          lastSlot_next = ~anyLater;
          byteIdx_next = 3'h0;
          state_next = ST_PUSH;
        end else begin
          slotIdx_next = slotIdx_reg + 3'h1;
        end
      end
      ST_PUSH: begin
        pushValid = 1'b1;
        if (fifoInReady) begin
          if (byteIdx_reg == `CVBF_BLOCK_BYTES - 1) begin
            slotIdx_next = slotIdx_reg + 3'h1;
            state_next = ST_SCAN;
          end else begin
            byteIdx_next = byteIdx_reg + 3'h1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // sequencer state
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      slotIdx_reg <= 3'h0;
      byteIdx_reg <= 3'h0;
      txWord_reg <= 40'h0000000000;
      lastSlot_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      slotIdx_reg <= slotIdx_next;
      byteIdx_reg <= byteIdx_next;
      txWord_reg <= txWord_next;
      lastSlot_reg <= lastSlot_next;
    end
  end

  // outgoing byte buffer, stalls the sequencer when full
  // most significant float byte first
  cvbf_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) txFifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inData({lastSlot_reg & (byteIdx_reg == `CVBF_BLOCK_BYTES - 1), blockByte(txWord_reg, byteIdx_reg)}),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(txValid),
    .outReady(txReady)
  );
  assign txData = fifoOut[7:0];
  assign txLast = fifoOut[8];

  // fifth slot is the master-written block
  // incoming bytes 0 to 3 value, 4 status
  assign rxBlockDone = rxValid & (rxCnt_reg == `CVBF_BLOCK_BYTES - 1);
  assign rxShortErr = rxValid & rxLast & (rxCnt_reg != `CVBF_BLOCK_BYTES - 1);

  // display block assembly
  always @(posedge clk_sys) begin
    if (!nrst) begin
      rxShift_reg <= 40'h0000000000;
      rxCnt_reg <= 3'h0;
      rxValue_reg <= 32'h00000000;
      rxStatus_reg <= 8'h00;
      dispValid_reg <= 1'b0;
      rxErr_reg <= 1'b0;
    end else begin
      if (rxValid) begin
        rxShift_reg <= {rxShift_reg[31:0], rxData};
        rxCnt_reg <= (rxBlockDone | rxShortErr) ? 3'h0 : rxCnt_reg + 3'h1;
      end
      if (rxBlockDone) begin
        rxValue_reg <= rxShift_reg[31:0];
        rxStatus_reg <= rxData;
        dispValid_reg <= 1'b1;
      end
      // short block flag, set wins over write-one clear
      if (rxShortErr) begin
        rxErr_reg <= 1'b1;
      end else if (wrStrobe && avs_address == `CVBF_OFF_STATUS && avs_byteenable[0] &&
          avs_writedata[`CVBF_STAT_RXERR]) begin
        rxErr_reg <= 1'b0;
      end
    end
  end

  // display source picks master value or slot one
  always @(posedge clk_sys) begin
    if (!nrst) begin
      dispValue_reg <= 32'h00000000;
      dispStatus_reg <= 8'h00;
    end else if (ctrl_reg[`CVBF_CTRL_DISPSRC]) begin
      dispValue_reg <= rxValue_reg;
      dispStatus_reg <= rxStatus_reg;
    end else begin
      // slot one's channel, its value and its own quality
      dispValue_reg <= chanValue(slotCfg_reg[10:8], srcValues);
      dispStatus_reg <= statusCode((slotCfg_reg[10:8] < 3'h5) ? srcQual[2*slotCfg_reg[10:8] +: 2] : `CVBF_Q_BAD,
        useNewProfile);
    end
  end
  assign dispValue = dispValue_reg;
  assign dispStatus = dispStatus_reg;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      commTimer_reg <= 25'h0000000;
      flashTimer_reg <= 25'h0000000;
      arrowPhase_reg <= 1'b0;
    end else begin
      if (cycStart | rxBlockDone) begin
        commTimer_reg <= COMM_TIMEOUT_CYC[24:0];
      end else if (commTimer_reg != 25'h0000000) begin
        commTimer_reg <= commTimer_reg - 25'h0000001;
      end
      if (commTimer_reg == 25'h0000000) begin
        flashTimer_reg <= 25'h0000000;
        arrowPhase_reg <= 1'b0;
      end else if (flashTimer_reg >= FLASH_CYC[24:0] - 25'h0000001) begin
        flashTimer_reg <= 25'h0000000;
        arrowPhase_reg <= ~arrowPhase_reg;
      end else begin
        flashTimer_reg <= flashTimer_reg + 25'h0000001;
      end
    end
  end
  assign commActive = (commTimer_reg != 25'h0000000);
  assign dispArrow = commActive & arrowPhase_reg;
endmodule // cvbf_framer

//--- testbench/cvbf_framer_assertions.sv
// port checks of the cyclic value block framer
`timescale 1ns/100ps
module cvbf_framer_assertions #(
  parameter COMM_TIMEOUT_CYC = 200,
  parameter FLASH_CYC = 20
) (
  input wire clk_sys,
  input wire nrst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire cycStart,
  input wire [7:0] txData,
  input wire txLast,
  input wire txValid,
  input wire txReady,
  input wire rxValid,
  input wire dispArrow,
  input wire commActive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [2:0] bytePos;
  int idleCnt;
  int holdCnt;
  // byte position in a block, cycles without traffic, length of an arrow phase
  always @(posedge clk_sys) begin
    if (!nrst) begin
      bytePos <= 3'h0;
      idleCnt <= 0;
      holdCnt <= 0;
    end else begin
      if (txValid && txReady) bytePos <= (bytePos == 3'h4) ? 3'h0 : bytePos + 3'h1;
      idleCnt <= (cycStart || rxValid) ? 0 : idleCnt + 1;
      holdCnt <= (!commActive || $changed(dispArrow)) ? 0 : holdCnt + 1;
    end
  end
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access waited more than one cycle");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no access");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("stalled byte changed");
  block_len_a: assert property (txValid && txLast |-> bytePos == 3'h4)
    else $error("cycle ended inside a block");
  comm_start_a: assert property (cycStart |-> ##[1:2] commActive)
    else $error("start did not raise activity");
  arrow_idle_a: assert property ((!commActive || $rose(commActive)) |-> !dispArrow)
    else $error("arrow lit while inactive or at start");
  arrow_rate_a: assert property (holdCnt <= 2 * FLASH_CYC + 2)
    else $error("arrow stopped flashing");
  comm_expire_a: assert property (idleCnt > COMM_TIMEOUT_CYC + 2 |-> !commActive)
    else $error("activity outlived its timeout");
endmodule // cvbf_framer_assertions
bind cvbf_framer cvbf_framer_assertions #(.COMM_TIMEOUT_CYC(COMM_TIMEOUT_CYC), .FLASH_CYC(FLASH_CYC)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cycStart(cycStart), .txData(txData), .txLast(txLast),
  .txValid(txValid), .txReady(txReady), .rxValid(rxValid), .dispArrow(dispArrow), .commActive(commActive));

//--- testbench/cvbf_master_model.sv
// far-side cyclic master: drains analog blocks, writes display blocks
`timescale 1ns/100ps
module cvbf_master_model (
  input wire clk_sys,
  input wire [7:0] txData,
  input wire txLast,
  input wire txValid,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxLast,
  input wire [1:0] stallMode
);
  logic [8:0] got [$];
  logic [2:0] phase = 3'h0;
  initial begin
    txReady = 1'b0;
    rxData = 8'h5A;
    rxValid = 1'b0;
    rxLast = 1'b0;
  end
  // bytes kept in arrival order, sign byte first
  always @(posedge clk_sys) begin
    phase <= phase + 3'h1;
    if (txValid && txReady) got.push_back({txLast, txData});
    case (stallMode)
      2'h0: txReady <= 1'b1;
      2'h1: txReady <= phase[0];
      2'h2: txReady <= (phase == 3'h7);
      default: txReady <= 1'b0;
    endcase
  end
  // value bytes then status, line inverted once released
  task automatic sendBlock(input logic [39:0] blk, input int n);
    for (int i = 0; i < n; i++) begin
      rxData <= blk[39 - 8 * i -: 8];
      rxValid <= 1'b1;
      rxLast <= (i == n - 1);
      @(posedge clk_sys);
    end
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    rxData <= ~rxData;
  endtask
endmodule // cvbf_master_model

//--- testbench/tb_top.sv
// self-checking bench of the cyclic value block framer
`timescale 1ns/100ps
`include "cvbf_defines.vh"
module tb_top;
  localparam int CT = 200;
  logic clk_sys, avs_waitrequest, txLast, txValid, txReady, rxValid, rxLast, dispArrow, commActive, np;
  logic nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, cycStart = 1'b0, estProfileNew = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, dispValue, rd, cfg;
  logic [7:0] txData, rxData, dispStatus;
  logic [9:0] chanUnit;
  logic [1:0] stallMode = 2'h0;
  logic [39:0] blk;
  logic [4:0] lastSeen;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  // channel values, qualities and the test tables
  logic [159:0] srcValues = {32'h3F800000, 32'h42480000, 32'h41C80000, 32'hC1200000, 32'h40F00000};
  logic [9:0] srcQual = 10'h386;
  logic [4:0] offT [5] = '{`CVBF_OFF_CTRL, `CVBF_OFF_SELECTOR, `CVBF_OFF_SLOTCFG, `CVBF_OFF_UNITS, 5'h1C};
  logic [31:0] rstT [5] = '{`CVBF_CTRL_RST, {24'h0, `CVBF_SELECTOR_RST}, `CVBF_SLOTCFG_RST, `CVBF_UNITS_RST, 32'h0};
  logic [7:0] selT [8] = '{8'h00, 8'h81, 8'h82, 8'h83, 8'h01, 8'h01, 8'h7F, 8'h7F};
  int nT [8] = '{4, 1, 2, 3, 4, 4, 4, 4};
  cvbf_framer #(.COMM_TIMEOUT_CYC(CT), .FLASH_CYC(20), .FIFO_DEPTH(4)) i_cvbf_framer (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cycStart(cycStart), .estProfileNew(estProfileNew),
    .srcValues(srcValues), .srcQual(srcQual), .txData(txData), .txLast(txLast), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast), .chanUnit(chanUnit),
    .dispValue(dispValue), .dispStatus(dispStatus), .dispArrow(dispArrow), .commActive(commActive));
  cvbf_master_model u_mst (.clk_sys(clk_sys), .txData(txData), .txLast(txLast), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast), .stallMode(stallMode));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  function automatic logic [7:0] stat(input logic [1:0] q, input logic p);
    if (q == `CVBF_Q_GOOD) return p ? `CVBF_NEW_GOOD : `CVBF_OLD_GOOD;
    if (q == `CVBF_Q_UNCERTAIN) return p ? `CVBF_NEW_UNC : `CVBF_OLD_UNC;
    return p ? `CVBF_NEW_BAD : `CVBF_OLD_BAD;
  endfunction
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // only the bench timeout ends a stuck access
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge clk_sys);
    cycStart <= 1'b1;
    @(posedge clk_sys);
    cycStart <= 1'b0;
  endtask
  task results;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    // reset values, an unmapped place, unit codes
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, offT[i], 32'h0);
      check(rd, rstT[i]);
    end
    bus(1'b1, 5'h1C, 32'hFFFFFFFF);
    bus(1'b0, 5'h1C, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `CVBF_OFF_UNITS, 32'h2E4);
    bus(1'b0, `CVBF_OFF_UNITS, 32'h0);
    check(rd, 32'h2E4);
    check(chanUnit, 10'h2E4);
    $display("test registers done");
    // display block from the master, then a short one
    bus(1'b1, `CVBF_OFF_CTRL, 32'h2);
    u_mst.sendBlock({32'hC0490FDB, 8'h80}, 5);
    bus(1'b0, `CVBF_OFF_DISPVAL, 32'h0);
    check(rd, 32'hC0490FDB);
    check({dispValue, dispStatus}, {32'hC0490FDB, 8'h80});
    u_mst.sendBlock(40'h1122334455, 3);
    bus(1'b0, `CVBF_OFF_DISPSTAT, 32'h0);
    check(rd, 32'h80);
    bus(1'b0, `CVBF_OFF_STATUS, 32'h0);
    check(rd & 32'hD, 32'hD);
    bus(1'b1, `CVBF_OFF_STATUS, 32'h8);
    bus(1'b0, `CVBF_OFF_STATUS, 32'h0);
    check(rd & 32'h8, 32'h0);
    $display("test display done");
    // every selector choice, all channels, stalls and a refused start
    for (int k = 0; k < 8; k++) begin
      np = (k == 5) || (k == 7);
      cfg = 32'hF;
      for (int s = 0; s < 4; s++) cfg = cfg | (32'((s + k) % 5) << (8 + 3 * s));
      estProfileNew <= k[0];
      bus(1'b1, `CVBF_OFF_CTRL, (k == 0 || k == 5 || k == 6) ? 32'h1 : 32'h0);
      bus(1'b1, `CVBF_OFF_SELECTOR, {24'h0, selT[k]});
      bus(1'b1, `CVBF_OFF_SLOTCFG, cfg);
      bus(1'b0, `CVBF_OFF_STATUS, 32'h0);
      check(rd[1], np);
      check({dispValue, dispStatus}, {srcValues[32 * (k % 5) +: 32], stat(srcQual[2 * (k % 5) +: 2], np)});
      stallMode <= 2'h3;
      pulse();
      repeat (2) @(posedge clk_sys);
      pulse();
      repeat (12) @(posedge clk_sys);
      stallMode <= 2'(k % 3);
      for (int s = 0; s < nT[k]; s++) begin
        while (u_mst.got.size() < 5) @(posedge clk_sys);
        for (int b = 0; b < 5; b++) {lastSeen[4 - b], blk[39 - 8 * b -: 8]} = u_mst.got.pop_front();
        check(blk, {srcValues[32 * ((s + k) % 5) +: 32], stat(srcQual[2 * ((s + k) % 5) +: 2], np)});
        check(lastSeen, (s == nT[k] - 1) ? 5'h01 : 5'h00);
      end
      repeat (40) @(posedge clk_sys);
      check(40'(u_mst.got.size()), 40'h0);
      $display("test selector %0d done", k);
    end
    // activity lapses without traffic
    repeat (CT + 20) @(posedge clk_sys);
    check({commActive, dispArrow}, 2'b00);
    bus(1'b0, `CVBF_OFF_STATUS, 32'h0);
    check(rd[0], 1'b0);
    $display("test activity done");
    results();
  end
endmodule // tb_top
